// *** pkg/tioc_cfg.svh ***
`ifndef TIOC_CFG_SVH
`define TIOC_CFG_SVH

// register byte offsets
`define TIOC_OFF_IOCTL_3D   8'h00
`define TIOC_OFF_IOCTL_4B   8'h04
`define TIOC_OFF_IOCTL_5B   8'h08
`define TIOC_OFF_MODE       8'h0C
`define TIOC_OFF_GREG_3D    8'h10
`define TIOC_OFF_GREG_4B    8'h14
`define TIOC_OFF_GREG_5B    8'h18
`define TIOC_OFF_STATUS     8'h1C

// i/o control field, bits 7 down to 4 of its register
`define TIOC_IOCTL_LSB      4
`define TIOC_IOCTL_MSB      7
`define TIOC_IOCTL_CAPTURE  3
`define TIOC_IOCTL_SRC      2
`define TIOC_IOCTL_BOTH     1
`define TIOC_IOCTL_FALL     0

// mode register fields
`define TIOC_MODE_BUFB      0
`define TIOC_MODE_PSC_LSB   4
`define TIOC_MODE_PSC_MSB   6
`define TIOC_PSC_UNDIVIDED  3'h0

// status register fields
`define TIOC_STAT_CAP_LSB   0
`define TIOC_STAT_CAP_MSB   2
`define TIOC_STAT_LVL_LSB   4
`define TIOC_STAT_LVL_MSB   6

// reset values
`define TIOC_RST_IOCTL      4'h0
`define TIOC_RST_GREG       16'h0000
`define TIOC_RST_PSC        3'h0

`endif

// *** pkg/tioc_pkg.sv ***
`default_nettype none
package tioc_pkg;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } tioc_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } tioc_wb_rsp_t;

   // compare actions, lower two field bits
   typedef enum logic [1:0] {
      TIOC_ACT_OFF    = 2'h0,
      TIOC_ACT_LOW    = 2'h1,
      TIOC_ACT_HIGH   = 2'h2,
      TIOC_ACT_TOGGLE = 2'h3
   } tioc_act_t;

endpackage
`default_nettype wire

// *** rtl/tioc_top.sv ***
// How it works
// - field bit 7 set makes the general register an input capture register, clear makes it compare.
// - compare with bit 6 clear drives the pin low first, then 00 off, 01 low, 10 high, 11 toggle on match.
// - compare with bit 6 set drives the pin high first, with the same four match actions.
// - pin capture takes rising edges for 00, falling for 01 and both edges when bit 5 is set.
// - for the ch3 d register, code 11xx captures on every ch4 counter count-up or count-down while ch4 prescale select is not 000.
// - for the ch4 b register, code 11xx captures on each ch3 c compare match or input capture.
// - for the ch5 b register, bit 6 is ignored in capture and the pin is always the source.
// - with ch4 prescale select 000 the ch3 d counter-based capture is invalid and captures nothing.
// - with buffer mode b set, the ch3 d register neither captures nor drives a compare output.
//
// Register access over Wishbone and the register offsets were decided locally.
`include "tioc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module tioc_top (
   input  wire logic                  clk_i,
   input  wire logic                  rstn_i,
   input  wire tioc_pkg::tioc_wb_req_t wb_req_i,
   output      tioc_pkg::tioc_wb_rsp_t wb_rsp_o,
   // index 0 ch3 d, 1 ch4 b, 2 ch5 b
   input  wire logic [2:0][15:0]      counter_i,
   input  wire logic                  ch4_count_up_i,
   input  wire logic                  ch4_count_down_i,
   input  wire logic                  ch3_c_event_i,
   input  wire logic [2:0]            pin_i,
   output      logic [2:0]            pin_o,
   output      logic [2:0]            pin_oe_n_o
);

   logic [2:0][3:0]  ioctl_r,  ioctl_nxt;
   logic [2:0][15:0] greg_r,   greg_nxt;
   logic [2:0]       lvl_r,    lvl_nxt;
   logic [2:0]       pin_q_r,  pin_q_nxt;
   logic [2:0]       match_r,  match_nxt;
   logic [2:0]       capf_r,   capf_nxt;
   logic             bufb_r,   bufb_nxt;
   logic [2:0]       psc_r,    psc_nxt;
   logic             ack_r,    ack_nxt;
   logic [31:0]      rdat_r,   rdat_nxt;

   logic             req;
   logic             wr_go;
   logic [2:0]       blocked;
   logic [2:0]       drive;

   always_comb begin
      req   = wb_req_i.cyc & wb_req_i.stb;
      // a write lands on the edge where the master sees ack
      wr_go = req & wb_req_i.we & ack_r;
      // with buffer mode b set, the ch3 d register is a buffer, no capture and no compare output
      blocked = {2'b00, bufb_r};
      for (int i = 0; i < 3; i++) begin
         drive[i] = ~ioctl_r[i][`TIOC_IOCTL_CAPTURE]
                  & (ioctl_r[i][1:0] != tioc_pkg::TIOC_ACT_OFF) & ~blocked[i];
      end
   end

   // bus group: the answer and its read data
   always_comb begin
      ack_nxt  = req & ~ack_r;
      rdat_nxt = rdat_r;
      // read data is latched at request time and stands with ack
      if (req & ~ack_r) begin
         rdat_nxt = 32'h0000_0000;
         case (wb_req_i.adr)
            `TIOC_OFF_IOCTL_3D: rdat_nxt[`TIOC_IOCTL_MSB:`TIOC_IOCTL_LSB] = ioctl_r[0];
            `TIOC_OFF_IOCTL_4B: rdat_nxt[`TIOC_IOCTL_MSB:`TIOC_IOCTL_LSB] = ioctl_r[1];
            `TIOC_OFF_IOCTL_5B: rdat_nxt[`TIOC_IOCTL_MSB:`TIOC_IOCTL_LSB] = ioctl_r[2];
            `TIOC_OFF_MODE: begin
               rdat_nxt[`TIOC_MODE_BUFB]                      = bufb_r;
               rdat_nxt[`TIOC_MODE_PSC_MSB:`TIOC_MODE_PSC_LSB] = psc_r;
            end
            `TIOC_OFF_GREG_3D:  rdat_nxt[15:0] = greg_r[0];
            `TIOC_OFF_GREG_4B:  rdat_nxt[15:0] = greg_r[1];
            `TIOC_OFF_GREG_5B:  rdat_nxt[15:0] = greg_r[2];
            `TIOC_OFF_STATUS: begin
               rdat_nxt[`TIOC_STAT_CAP_MSB:`TIOC_STAT_CAP_LSB] = capf_r;
               rdat_nxt[`TIOC_STAT_LVL_MSB:`TIOC_STAT_LVL_LSB] = lvl_r;
            end
            default: rdat_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      logic        edge_hit;
      logic        trig;
      logic        match;
      logic [3:0]  wf;
      logic [7:0]  wsel;
      edge_hit  = 1'b0;
      trig      = 1'b0;
      match     = 1'b0;
      wf        = 4'h0;
      wsel      = 8'h00;
      ioctl_nxt = ioctl_r;
      greg_nxt  = greg_r;
      lvl_nxt   = lvl_r;
      capf_nxt  = capf_r;
      bufb_nxt  = bufb_r;
      psc_nxt   = psc_r;
      pin_q_nxt = pin_i;

      // software writes first so that hardware events below win
      if (wr_go) begin
         wf = wb_req_i.dat[`TIOC_IOCTL_MSB:`TIOC_IOCTL_LSB];
         case (wb_req_i.adr)
            `TIOC_OFF_IOCTL_3D, `TIOC_OFF_IOCTL_4B, `TIOC_OFF_IOCTL_5B: begin
               if (wb_req_i.sel[0]) begin
                  for (int i = 0; i < 3; i++) begin
                     wsel = 8'(`TIOC_OFF_IOCTL_3D + 4 * i);
                     if (wb_req_i.adr == wsel) begin
                        ioctl_nxt[i] = wf;
                        // initial level is set as the compare mode is chosen
                        if (~wf[`TIOC_IOCTL_CAPTURE] && wf[1:0] != tioc_pkg::TIOC_ACT_OFF) begin
                           lvl_nxt[i] = wf[`TIOC_IOCTL_SRC];
                        end
                     end
                  end
               end
            end
            `TIOC_OFF_MODE: begin
               if (wb_req_i.sel[0]) begin
                  bufb_nxt = wb_req_i.dat[`TIOC_MODE_BUFB];
                  psc_nxt  = wb_req_i.dat[`TIOC_MODE_PSC_MSB:`TIOC_MODE_PSC_LSB];
               end
            end
            `TIOC_OFF_GREG_3D, `TIOC_OFF_GREG_4B, `TIOC_OFF_GREG_5B: begin
               for (int i = 0; i < 3; i++) begin
                  wsel = 8'(`TIOC_OFF_GREG_3D + 4 * i);
                  if (wb_req_i.adr == wsel) begin
                     if (wb_req_i.sel[0]) greg_nxt[i][7:0]  = wb_req_i.dat[7:0];
                     if (wb_req_i.sel[1]) greg_nxt[i][15:8] = wb_req_i.dat[15:8];
                  end
               end
            end
            `TIOC_OFF_STATUS: begin
               if (wb_req_i.sel[0]) begin
                  capf_nxt = capf_r & ~wb_req_i.dat[`TIOC_STAT_CAP_MSB:`TIOC_STAT_CAP_LSB];
               end
            end
            default: ;
         endcase
      end

      for (int i = 0; i < 3; i++) begin
         // pin samples are already synchronous, one stage is enough for edges
         if (ioctl_r[i][`TIOC_IOCTL_BOTH]) begin
            edge_hit = pin_i[i] ^ pin_q_r[i];
         end else if (ioctl_r[i][`TIOC_IOCTL_FALL]) begin
            edge_hit = ~pin_i[i] & pin_q_r[i];
         end else begin
            edge_hit = pin_i[i] & ~pin_q_r[i];
         end
         trig = edge_hit;
         if (ioctl_r[i][`TIOC_IOCTL_SRC]) begin
            case (i)
               0: trig = (ch4_count_up_i | ch4_count_down_i)
                         & (psc_r != `TIOC_PSC_UNDIVIDED);
               1: trig = ch3_c_event_i;
               default: trig = edge_hit;
            endcase
         end
         if (ioctl_r[i][`TIOC_IOCTL_CAPTURE] & trig & ~blocked[i]) begin
            greg_nxt[i] = counter_i[i];
            capf_nxt[i] = 1'b1;
         end

         // act once per match, not for every cycle the counter sits on it
         match        = counter_i[i] == greg_r[i];
         match_nxt[i] = match;
         if (drive[i] & match & ~match_r[i]) begin
            case (tioc_pkg::tioc_act_t'(ioctl_r[i][1:0]))
               tioc_pkg::TIOC_ACT_LOW:    lvl_nxt[i] = 1'b0;
               tioc_pkg::TIOC_ACT_HIGH:   lvl_nxt[i] = 1'b1;
               tioc_pkg::TIOC_ACT_TOGGLE: lvl_nxt[i] = ~lvl_r[i];
               default:                   lvl_nxt[i] = lvl_r[i];
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ioctl_r <= {3{`TIOC_RST_IOCTL}};
         greg_r  <= {3{`TIOC_RST_GREG}};
         lvl_r   <= 3'h0;
         // history starts low, so a pin held high out of reset reads as a rising edge
         pin_q_r <= 3'h0;
         match_r <= 3'h0;
         capf_r  <= 3'h0;
         bufb_r  <= 1'b0;
         psc_r   <= `TIOC_RST_PSC;
      end else begin
         ioctl_r <= ioctl_nxt;
         greg_r  <= greg_nxt;
         lvl_r   <= lvl_nxt;
         pin_q_r <= pin_q_nxt;
         match_r <= match_nxt;
         capf_r  <= capf_nxt;
         bufb_r  <= bufb_nxt;
         psc_r   <= psc_nxt;
      end
   end

   // bus answer registers, kept apart from the timer state they report
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end else begin
         ack_r  <= ack_nxt;
         rdat_r <= rdat_nxt;
      end
   end

   assign wb_rsp_o.ack = ack_r;
   assign wb_rsp_o.dat = rdat_r;
   assign pin_o        = lvl_r;
   assign pin_oe_n_o   = ~drive;

endmodule

`default_nettype wire

// *** test/tioc_top_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module tioc_top_asserts (
   input wire logic                   clk_i,
   input wire logic                   rstn_i,
   input wire tioc_pkg::tioc_wb_req_t wb_req_i,
   input wire tioc_pkg::tioc_wb_rsp_t wb_rsp_o,
   input wire logic [2:0]             pin_o,
   input wire logic [2:0]             pin_oe_n_o
);
   logic [2:0][3:0] ioc_r;
   logic            bufb_r;
   logic            wr;
   assign wr = wb_rsp_o.ack && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_req_i.sel[0];
   // shadow of field writes, so pin rules are checked from the ports alone
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ioc_r  <= '0;
         bufb_r <= 1'h0;
      end else if (wr && wb_req_i.adr == 8'h0C) begin
         bufb_r <= wb_req_i.dat[0];
      end else if (wr && wb_req_i.adr < 8'h0C && wb_req_i.adr[1:0] == 2'h0) begin
         ioc_r[wb_req_i.adr[3:2]] <= wb_req_i.dat[7:4];
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   a_ack_one_wait: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
      else $error("ack not one cycle after request");
   a_ack_one_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
      else $error("ack longer than one cycle");
   a_unmapped_zero: assert property (wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr > 8'h1C
      |-> wb_rsp_o.dat == 32'h0) else $error("unmapped read not zero");
   a_capture_no_drive: assert property (ioc_r[0][3] || bufb_r |-> pin_oe_n_o[0])
      else $error("ch3 d pin driven in capture or buffer mode");
   a_ch5_no_drive: assert property (ioc_r[2][3] |-> pin_oe_n_o[2])
      else $error("ch5 b pin driven in capture mode");
   a_disabled_no_drive: assert property (ioc_r[1][1:0] == 2'h0 |-> pin_oe_n_o[1])
      else $error("ch4 b pin driven while output disabled");
   a_compare_drives: assert property (!ioc_r[1][3] && ioc_r[1][1:0] != 2'h0 |-> !pin_oe_n_o[1])
      else $error("ch4 b pin not driven in compare mode");
   a_initial_level: assert property (wr && wb_req_i.adr == 8'h04 && !wb_req_i.dat[7]
      && wb_req_i.dat[5:4] != 2'h0 |=> pin_o[1] == $past(wb_req_i.dat[6]))
      else $error("ch4 b initial level wrong");
   a_oe_steady: assert property (!wr |=> $stable(pin_oe_n_o))
      else $error("pin enable changed without a write");
endmodule
bind tioc_top tioc_top_asserts tioc_top_asserts_inst (.clk_i(clk_i), .rstn_i(rstn_i),
   .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o));
`default_nettype wire

// *** test/tioc_pins.sv ***
`timescale 1ns/10ps
`default_nettype none
module tioc_pins (
   input  wire logic [2:0] pin_o,
   input  wire logic [2:0] pin_oe_n_o,
   input  wire logic [2:0] lvl_i,
   output logic [2:0]      pin_i
);
   // a driven pin reads back the device level, a released one follows the outside source
   assign pin_i = (pin_oe_n_o & lvl_i) | (~pin_oe_n_o & pin_o);
endmodule
`default_nettype wire

// *** test/tb_tioc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_tioc_top;
   logic clk_i, rstn_i, up, dn, ev, ok;
   tioc_pkg::tioc_wb_req_t req;
   tioc_pkg::tioc_wb_rsp_t rsp;
   logic [2:0][15:0] cnt;
   logic [2:0] lvl, pin_in, pin_out, oe_n;
   logic [31:0] q;
   logic [7:0] md [4] = '{8'h10, 8'h10, 8'h00, 8'h11};
   int errors, comparisons, c;
   tioc_top tioc_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .wb_req_i(req), .wb_rsp_o(rsp),
      .counter_i(cnt), .ch4_count_up_i(up), .ch4_count_down_i(dn), .ch3_c_event_i(ev),
      .pin_i(pin_in), .pin_o(pin_out), .pin_oe_n_o(oe_n));
   tioc_pins tioc_pins_inst (.pin_o(pin_out), .pin_oe_n_o(oe_n), .lvl_i(lvl), .pin_i(pin_in));
   initial begin
      clk_i = 1'h0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic print_verdict();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // waits are bounded so a silent slave ends the run instead of hanging it
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      req <= '{1'h1, 1'h1, w, a, 4'hF, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp.ack !== 1'h1 && n < 16);
      ok = (rsp.ack === 1'h1);
      q = rsp.dat;
      req <= '0;
      @(posedge clk_i);
      if (!ok) begin
         errors++;
         print_verdict();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'h0, 32'h0);
      chk(q, e);
   endtask
   initial begin
      req = '0;
      cnt = '0;
      lvl = '0;
      up = 1'h0;
      dn = 1'h0;
      ev = 1'h0;
      rstn_i = 1'h0;
      step(10);
      rstn_i <= 1'h1;
      step(1);
      chk(32'(oe_n), 32'h7);
      rd(8'h00, 32'h0);
      bus(8'h20, 1'h1, 32'hFF);
      rd(8'h20, 32'h0);
      $display("test reset done");
      for (int ch = 0; ch < 3; ch++) begin
         for (c = 0; c < 3; c++) begin
            bus(8'(4 * ch), 1'h1, 32'(((ch == 2) ? 8'hC0 : 8'h80) + 8'(16 * c)));
            bus(8'(16 + 4 * ch), 1'h1, 32'h0);
            cnt <= {3{16'h1A2B}};
            lvl[ch] <= 1'h1;
            step(2);
            rd(8'(16 + 4 * ch), (c == 1) ? 32'h0 : 32'h1A2B);
            cnt <= {3{16'h3C4D}};
            lvl[ch] <= 1'h0;
            step(2);
            rd(8'(16 + 4 * ch), (c == 0) ? 32'h1A2B : 32'h3C4D);
         end
      end
      rd(8'h1C, 32'h7);
      bus(8'h1C, 1'h1, 32'h5);
      rd(8'h1C, 32'h2);
      $display("test capture done");
      bus(8'h00, 1'h1, 32'hC0);
      for (c = 0; c < 4; c++) begin
         bus(8'h0C, 1'h1, 32'(md[c]));
         cnt <= {3{16'h0A00 + 16'(c)}};
         up <= (c != 1);
         dn <= (c == 1);
         step(1);
         up <= 1'h0;
         dn <= 1'h0;
         step(1);
         rd(8'h10, (c < 2) ? 32'h0A00 + 32'(c) : 32'h0A01);
      end
      rd(8'h0C, 32'h11);
      bus(8'h00, 1'h1, 32'h10);
      chk(32'(oe_n), 32'h7);
      bus(8'h0C, 1'h1, 32'h0);
      bus(8'h04, 1'h1, 32'hF0);
      cnt <= {3{16'h0456}};
      ev <= 1'h1;
      step(1);
      ev <= 1'h0;
      step(1);
      rd(8'h14, 32'h0456);
      rd(8'h04, 32'hF0);
      $display("test counter and cascade done");
      bus(8'h14, 1'h1, 32'h50);
      for (c = 0; c < 8; c++) begin
         cnt <= '0;
         bus(8'h04, 1'h1, 32'(c << 4));
         chk(32'(oe_n[1]), 32'(c[1:0] == 2'h0));
         if (c[1:0] != 2'h0) chk(32'(pin_out[1]), 32'(c[2]));
         cnt <= {3{16'h0050}};
         step(2);
         if (c[1:0] != 2'h0) chk(32'(pin_out[1]), 32'((c[1:0] == 2'h3) ? !c[2] : c[1]));
      end
      $display("test compare done");
      print_verdict();
   end
endmodule
`default_nettype wire
